// File: bench/nco_partner.sv
// consumer model: counts active cycles and rising edges of the output
`timescale 1ns/1ps
`default_nettype none
module nco_partner (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic sig,
   input wire logic win,
   output logic [15:0] high_cnt,
   output logic [15:0] rise_cnt
);
   logic prev;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prev <= 1'b0;
         high_cnt <= 16'h0000;
         rise_cnt <= 16'h0000;
      end else begin
         prev <= sig;
         high_cnt <= win ? high_cnt + {15'h0000, sig} : 16'h0000;
         rise_cnt <= win ? rise_cnt + {15'h0000, sig & ~prev} : 16'h0000;
      end
   end
endmodule : nco_partner
`default_nettype wire

// File: bench/nco_top_tb_top.sv
// self-checking bench for the numeric oscillator
`timescale 1ns/1ps
`default_nettype none
module nco_top_tb_top;
   import nco_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic win = 1'b0;
   logic srun = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [31:0] dat = 32'h00000000;
   logic [31:0] rdat;
   logic ack, fout, pout, poe, irq, keep;
   logic [10:0] src = 11'h000;
   logic [15:0] hc, rc;
   logic [7:0] expq[$];
   logic [19:0] v;
   int errors = 0;
   int checked = 0;
   int seed = 87;
   nco_top i_nco_top (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .clk_src(src), .final_output(fout), .pin_out(pout),
      .pin_oe(poe), .irq_request(irq), .fast_osc_keep(keep));
   nco_partner i_nco_partner (.clk_sys(clk_sys), .resetn(resetn), .sig(fout), .win(win),
      .high_cnt(hc), .rise_cnt(rc));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic final_report();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h000000, d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         final_report();
      end
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk_sys);
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      expq.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask : rd
   task automatic put3(input logic [5:0] b, input logic [19:0] x);
      wr(b + 6'h08, {4'h0, x[19:16]});
      wr(b + 6'h04, x[15:8]);
      wr(b, x[7:0]);
   endtask : put3
   task automatic get3(input logic [5:0] b, input logic [19:0] x);
      rd(b + 6'h08, {4'h0, x[19:16]});
      rd(b + 6'h04, x[15:8]);
      rd(b, x[7:0]);
   endtask : get3
   task automatic meas(input logic [15:0] eh, input logic [15:0] er);
      repeat (8) @(posedge clk_sys);
      win <= 1'b1;
      repeat (64) @(posedge clk_sys);
      #1;
      check({16'h0000, hc}, {16'h0000, eh});
      check({16'h0000, rc}, {16'h0000, er});
      win <= 1'b0;
      @(posedge clk_sys);
   endtask : meas
   // ----------------------------------------
   // read result watcher
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) check(rdat, {24'h0, expq.pop_front()});
   end
   // reference clock pin: toggles on every rising clk_sys edge while srun is set
   always @(posedge clk_sys) begin
      src[CKS_REF_CLK] <= srun && !src[CKS_REF_CLK];
   end
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      for (int a = 0; a < 10; a++) rd(6'(a * 4), 8'h00);
      v = 20'($random(seed));
      put3(OFS_INC_LOW, v);
      get3(OFS_INC_LOW, v);
      v = 20'($random(seed));
      put3(OFS_ACC_LOW, v);
      repeat (10) @(posedge clk_sys);
      get3(OFS_ACC_LOW, v);
      wr(OFS_IRQ, 8'h02);
      wr(OFS_CTRL, 8'h10);
      rd(OFS_CTRL, 8'h30);
      check({31'h0, fout}, 32'h1);
      rd(OFS_IRQ, 8'h03);
      wr(OFS_IRQ, 8'h00);
      wr(OFS_CTRL, 8'h00);
      wr(OFS_CLK, {4'h0, CKS_SYS});
      put3(OFS_INC_LOW, 20'h80000);
      wr(OFS_IRQ, 8'h1e);
      wr(OFS_CTRL, 8'h80);
      meas(16'd32, 16'd16);
      check({31'h0, irq}, 32'h1);
      check({30'h0, poe, pout}, {30'h0, 1'b1, fout});
      put3(OFS_INC_LOW, 20'h40000);
      meas(16'd32, 16'd8);
      put3(OFS_INC_LOW, 20'h80000);
      wr(OFS_CTRL, 8'h81);
      meas(16'd32, 16'd32);
      wr(OFS_CLK, {4'h2, CKS_SYS});
      meas(16'd64, 16'd0);
      srun <= 1'b1;
      wr(OFS_CLK, {4'h0, CKS_REF_CLK});
      wr(OFS_CTRL, 8'h80);
      meas(16'd32, 16'd8);
      srun <= 1'b0;
      wr(OFS_CTRL, 8'h00);
      repeat (6) @(posedge clk_sys);
      wr(OFS_IRQ, 8'h0e);
      rd(OFS_IRQ, 8'h0e);
      check({30'h0, irq, fout}, 32'h0);
      wr(OFS_CLK, 8'h00);
      wr(OFS_CTRL, 8'h80);
      @(posedge clk_sys);
      check({31'h0, keep}, 32'h1);
      final_report();
   end
endmodule : nco_top_tb_top
`default_nettype wire

// File: src/nco_clk_sel.sv
// input clock source synchroniser and edge selector
`timescale 1ns/1ps
`default_nettype none
module nco_clk_sel
   import nco_pkg::*;
#(
   parameter int N = NUM_SRC
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [N-1:0] src,
   input wire logic [3:0] sel,
   output logic tick
);
   if (N < 1 || N > 16) begin : g_bad_n
      $error("nco_clk_sel: N out of range");
   end

   logic [N-1:0] sync1;
   logic [N-1:0] sync2;
   logic [N-1:0] prev;
   logic [N-1:0] rise;

   // ----------------------------------------
   // two-stage sync, then edge detect
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
      end else if (ce) begin
         sync1 <= src;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   assign rise = sync2 & ~prev;

   // system clock gives a tick every cycle; reserved codes never tick
   always_comb begin
      tick = 1'b0;
      if (sel == CKS_SYS) begin
         tick = 1'b1;
      end else if (sel < CKS_FIRST_RSVD && 32'(sel) < N) begin
         tick = rise[sel];
      end
   end
endmodule : nco_clk_sel
`default_nettype wire

// File: src/nco_core.sv
// accumulator, increment buffer and output shaping
`timescale 1ns/1ps
`default_nettype none
module nco_core
   import nco_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   nco_core_if.core cb
);
   logic [19:0] incr_buf;
   logic [1:0] load_cnt;
   logic [20:0] sum;
   logic carry;
   logic [7:0] width_cnt;
   logic step;

   assign step = ce && cb.enable && cb.tick && (cb.acc_wr_en == 3'h0);
   assign sum = {1'b0, cb.acc} + {1'b0, incr_buf}; // R2
   assign carry = sum[ACC_W]; // R3

   // ----------------------------------------
   // increment buffer
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         incr_buf <= RST_WORD; // R19
         load_cnt <= 2'h0;
      end else if (ce) begin
         if (!cb.enable) begin
            load_cnt <= 2'h0;
            if (cb.incr_any_wr) begin
               incr_buf <= cb.incr_sw; // R7
            end
         end else if (cb.incr_low_wr) begin
            load_cnt <= INC_LOAD_EDGES; // R5
         end else if (cb.tick && load_cnt != 2'h0) begin
            load_cnt <= load_cnt - 2'h1;
            if (load_cnt == 2'h1) begin
               incr_buf <= cb.incr_sw; // R5
            end
         end
      end
   end

   // ----------------------------------------
   // accumulator
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cb.acc <= RST_WORD; // R19
         cb.ovf <= 1'b0;
      end else if (ce) begin
         cb.ovf <= step && carry; // R3
         if (cb.acc_wr_en != 3'h0) begin
            if (cb.acc_wr_en[0]) cb.acc[7:0] <= cb.wr_data; // R1
            if (cb.acc_wr_en[1]) cb.acc[15:8] <= cb.wr_data; // R1
            if (cb.acc_wr_en[2]) cb.acc[19:16] <= cb.wr_data[3:0]; // R1
         end else if (step) begin
            cb.acc <= sum[ACC_W-1:0]; // R2 R25
         end
      end
   end

   // ----------------------------------------
   // output shaping
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cb.out_raw <= 1'b0;
         width_cnt <= 8'h00;
      end else if (ce) begin
         if (!cb.enable) begin
            cb.out_raw <= 1'b0; // R25
            width_cnt <= 8'h00;
         end else if (step) begin
            if (!cb.pfm) begin
               width_cnt <= 8'h00;
               if (carry) cb.out_raw <= ~cb.out_raw; // R9
            end else if (carry) begin
               cb.out_raw <= 1'b1; // R11 R13
               width_cnt <= nco_pulse_len(cb.pws); // R12
            end else if (width_cnt != 8'h00) begin
               width_cnt <= width_cnt - 8'h01;
               if (width_cnt == 8'h01) cb.out_raw <= 1'b0; // R11
            end else begin
               cb.out_raw <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb_clk @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_pf_start;
      ce && cb.enable && cb.pfm && cb.tick && cb.acc_wr_en == 3'h0 && carry;
   endsequence
   acc_hold_a: assert property (ce && !cb.enable && cb.acc_wr_en == 3'h0 |=> $stable(cb.acc))
      else $error("accumulator moved while disabled"); // R25
   ovf_tick_a: assert property (cb.ovf |-> $past(cb.tick) && $past(cb.enable))
      else $error("overflow without input clock edge"); // R3
   inc_imm_a: assert property (ce && !cb.enable && cb.incr_any_wr |=> incr_buf == $past(cb.incr_sw))
      else $error("increment buffer not loaded while disabled"); // R7
   pf_rise_a: assert property (s_pf_start |=> cb.out_raw && width_cnt == $past(nco_pulse_len(cb.pws)))
      else $error("pulse did not start on overflow edge"); // R11 R12
   fdc_toggle_a: assert property (ce && cb.enable && !cb.pfm && step && carry
         |=> cb.out_raw != $past(cb.out_raw))
      else $error("fixed duty output failed to toggle"); // R9
   idle_out_a: assert property (ce && !cb.enable |=> !cb.out_raw)
      else $error("output active while disabled"); // R25
endmodule : nco_core
`default_nettype wire

// File: src/nco_core_if.sv
// link between register file and oscillator core
`timescale 1ns/1ps
`default_nettype none
interface nco_core_if;
   import nco_pkg::*;
   logic tick;
   logic enable;
   logic pfm;
   logic [2:0] pws;
   logic [19:0] incr_sw;
   logic incr_low_wr;
   logic incr_any_wr;
   logic [2:0] acc_wr_en;
   logic [7:0] wr_data;
   logic [19:0] acc;
   logic ovf;
   logic out_raw;

   modport core (
      input tick, enable, pfm, pws, incr_sw, incr_low_wr, incr_any_wr, acc_wr_en, wr_data,
      output acc, ovf, out_raw
   );
   modport ctrl (
      output tick, enable, pfm, pws, incr_sw, incr_low_wr, incr_any_wr, acc_wr_en, wr_data,
      input acc, ovf, out_raw
   );
endinterface : nco_core_if
`default_nettype wire

// File: src/nco_pkg.sv
// constants and helpers for the numeric oscillator
package nco_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int ACC_W = 20;
   localparam int NUM_SRC = 11;
   localparam int ADR_W = 6;
   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_CLK = 6'h04;
   localparam logic [5:0] OFS_ACC_LOW = 6'h08;
   localparam logic [5:0] OFS_ACC_HIGH = 6'h0c;
   localparam logic [5:0] OFS_ACC_UPPER = 6'h10;
   localparam logic [5:0] OFS_INC_LOW = 6'h14;
   localparam logic [5:0] OFS_INC_HIGH = 6'h18;
   localparam logic [5:0] OFS_INC_UPPER = 6'h1c;
   localparam logic [5:0] OFS_IRQ = 6'h20;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_OUT_BIT = 5;
   localparam int CTRL_POL_BIT = 4;
   localparam int CTRL_PFM_BIT = 0;
   localparam int CLK_PWS_LSB = 5;
   localparam int CLK_CKS_LSB = 0;
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_IE_BIT = 1;
   localparam int IRQ_PERIPHERAL_IRQ_ENABLE_BIT = 2;
   localparam int IRQ_GIE_BIT = 3;
   localparam int IRQ_PIN_BIT = 4;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [19:0] RST_WORD = 20'h00000;
   // ----------------------------------------
   // input clock codes
   // ----------------------------------------
   localparam logic [3:0] CKS_FAST_OSC = 4'h0;
   localparam logic [3:0] CKS_SYS = 4'h1;
   localparam logic [3:0] CKS_MED_500K = 4'h3;
   localparam logic [3:0] CKS_MED_32K = 4'h4;
   localparam logic [3:0] CKS_REF_CLK = 4'h6;
   localparam logic [3:0] CKS_FIRST_RSVD = 4'hb;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam logic [1:0] INC_LOAD_EDGES = 2'h2;

   // active time in input clock periods
   function automatic logic [7:0] nco_pulse_len(input logic [2:0] pws);
      nco_pulse_len = 8'h01 << pws;
   endfunction : nco_pulse_len

   // one byte of a 20-bit word
   function automatic logic [7:0] nco_byte(input logic [19:0] w, input logic [1:0] idx);
      logic [23:0] ext;
      ext = {4'h0, w};
      nco_byte = ext[idx*8 +: 8];
   endfunction : nco_byte
endpackage : nco_pkg

// File: src/nco_top.sv
// numeric oscillator with wishbone register file
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: 20-bit accumulator readable and writable as low, high, upper bytes.
// R2: each selected input clock edge adds buffered increment into accumulator.
// R3: adder carry is the raw overflow pulse.
// R4: 20-bit increment held in low, high, upper byte registers.
// R5: enabled: low increment write loads buffer on second following input edge.
// R6: software writes upper and high before low when running.
// R7: disabled: any increment write loads the buffer at once.
// R8: buffer is hidden; increment reads return software values.
// R9: fixed-duty mode toggles output on every overflow.
// R10: control bit 0 selects pulse mode when set, toggle mode when clear.
// R11: pulse mode goes active on overflow edge, inactive after pulse width.
// R12: 3-bit width field gives two to the field input periods.
// R13: width longer than overflow interval keeps output active.
// R14: control bit 4 inverts the output as last stage.
// R15: polarity change with interrupt enabled raises the interrupt flag.
// R16: final output goes to peripherals and optionally a pin.
// R17: overflow sets flag; request needs module, irq, peripheral, global enables.
// R18: software clears the flag; hardware never does.
// R19: reset clears all oscillator registers to zero.
// R20: runs from selected input clock independent of system clock; code synchronises it to clk_sys and steps only on clk_sys edges.
// R21: enabled with fast oscillator selected keeps that oscillator running.
// R22: control bit 7 enables the module.
// R23: control bit 5 reads the current module output.
// R24: 4-bit clock select field chooses input; 1011 to 1111 reserved.
// R25: disabled: accumulator holds, no overflow, output inactive.
module nco_top
   import nco_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NUM_SRC-1:0] clk_src,
   output logic final_output,
   output logic pin_out,
   output logic pin_oe,
   output logic irq_request,
   output logic fast_osc_keep
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic module_enable;
   logic output_invert;
   logic pulse_mode_select;
   logic [2:0] pulse_width_select;
   logic [3:0] input_clock_select;
   logic [19:0] incr;
   logic overflow_irq_flag;
   logic overflow_irq_enable;
   logic peripheral_irq_enable;
   logic global_irq_enable;
   logic pin_drive;
   logic incr_low_wr;
   logic incr_any_wr;
   logic [2:0] acc_wr_en;
   logic [7:0] wr_byte;
   logic prev_invert;
   logic pol_event;
   logic do_write;
   logic [7:0] next_rd;
   logic tick;

   nco_core_if cif ();

   assign do_write = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
   assign wr_byte = wb_dat_i[7:0];

   // ----------------------------------------
   // input clock selection
   // ----------------------------------------
   nco_clk_sel #(.N(NUM_SRC)) u_clk_sel (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .src(clk_src),
      .sel(input_clock_select),
      .tick(tick)
   );

   // ----------------------------------------
   // core hookup
   // ----------------------------------------
   assign cif.tick = tick; // R20
   assign cif.enable = module_enable; // R22
   assign cif.pfm = pulse_mode_select; // R10
   assign cif.pws = pulse_width_select; // R12
   assign cif.incr_sw = incr;
   assign cif.incr_low_wr = incr_low_wr;
   assign cif.incr_any_wr = incr_any_wr;
   assign cif.acc_wr_en = acc_wr_en;
   assign cif.wr_data = wr_byte;

   nco_core u_core (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .cb(cif.core)
   );

   // ----------------------------------------
   // wishbone handshake
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
      end else if (ce) begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   // ----------------------------------------
   // control and clock select writes
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         module_enable <= 1'b0; // R19
         output_invert <= 1'b0;
         pulse_mode_select <= 1'b0;
         pulse_width_select <= 3'h0;
         input_clock_select <= 4'h0;
      end else if (ce && do_write) begin
         if (wb_adr_i == OFS_CTRL) begin
            module_enable <= wr_byte[CTRL_EN_BIT]; // R22
            output_invert <= wr_byte[CTRL_POL_BIT]; // R14
            pulse_mode_select <= wr_byte[CTRL_PFM_BIT]; // R10
         end
         if (wb_adr_i == OFS_CLK) begin
            pulse_width_select <= wr_byte[CLK_PWS_LSB +: 3]; // R12
            input_clock_select <= wr_byte[CLK_CKS_LSB +: 4]; // R24
         end
      end
   end

   // ----------------------------------------
   // increment and accumulator writes
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         incr <= RST_WORD; // R19
         incr_low_wr <= 1'b0;
         incr_any_wr <= 1'b0;
         acc_wr_en <= 3'h0;
      end else if (ce) begin
         incr_low_wr <= do_write && wb_adr_i == OFS_INC_LOW; // R5
         incr_any_wr <= do_write && (wb_adr_i == OFS_INC_LOW || wb_adr_i == OFS_INC_HIGH
            || wb_adr_i == OFS_INC_UPPER); // R7
         acc_wr_en[0] <= do_write && wb_adr_i == OFS_ACC_LOW; // R1
         acc_wr_en[1] <= do_write && wb_adr_i == OFS_ACC_HIGH; // R1
         acc_wr_en[2] <= do_write && wb_adr_i == OFS_ACC_UPPER; // R1
         if (do_write) begin
            case (wb_adr_i)
               OFS_INC_LOW: begin
                  incr[7:0] <= wr_byte; // R4
               end
               OFS_INC_HIGH: begin
                  incr[15:8] <= wr_byte; // R4
               end
               OFS_INC_UPPER: begin
                  incr[19:16] <= wr_byte[3:0]; // R4
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // interrupt flag and enables
   // ----------------------------------------
   assign pol_event = overflow_irq_enable && (prev_invert != output_invert); // R15

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         overflow_irq_flag <= 1'b0;
         overflow_irq_enable <= 1'b0;
         peripheral_irq_enable <= 1'b0;
         global_irq_enable <= 1'b0;
         pin_drive <= 1'b0;
         prev_invert <= 1'b0;
      end else if (ce) begin
         prev_invert <= output_invert;
         if (do_write && wb_adr_i == OFS_IRQ) begin
            overflow_irq_enable <= wr_byte[IRQ_IE_BIT];
            peripheral_irq_enable <= wr_byte[IRQ_PERIPHERAL_IRQ_ENABLE_BIT];
            global_irq_enable <= wr_byte[IRQ_GIE_BIT];
            pin_drive <= wr_byte[IRQ_PIN_BIT]; // R16
         end
         if (cif.ovf || pol_event) begin
            overflow_irq_flag <= 1'b1; // R17 R15
         end else if (do_write && wb_adr_i == OFS_IRQ && !wr_byte[IRQ_FLAG_BIT]) begin
            overflow_irq_flag <= 1'b0; // R18
         end
      end
   end

   // ----------------------------------------
   // output stage
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         final_output <= 1'b0;
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
         irq_request <= 1'b0;
         fast_osc_keep <= 1'b0;
      end else if (ce) begin
         final_output <= cif.out_raw ^ output_invert; // R14 R16
         pin_out <= cif.out_raw ^ output_invert; // R16
         pin_oe <= pin_drive; // R16
         irq_request <= overflow_irq_flag && module_enable && overflow_irq_enable
            && peripheral_irq_enable && global_irq_enable; // R17
         fast_osc_keep <= module_enable && input_clock_select == CKS_FAST_OSC; // R21
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_comb begin
      next_rd = 8'h00;
      case (wb_adr_i)
         OFS_CTRL: begin
            next_rd[CTRL_EN_BIT] = module_enable;
            next_rd[CTRL_OUT_BIT] = final_output; // R23
            next_rd[CTRL_POL_BIT] = output_invert;
            next_rd[CTRL_PFM_BIT] = pulse_mode_select;
         end
         OFS_CLK: begin
            next_rd[CLK_PWS_LSB +: 3] = pulse_width_select;
            next_rd[CLK_CKS_LSB +: 4] = input_clock_select;
         end
         OFS_ACC_LOW: begin
            next_rd = nco_byte(cif.acc, 2'h0); // R1
         end
         OFS_ACC_HIGH: begin
            next_rd = nco_byte(cif.acc, 2'h1);
         end
         OFS_ACC_UPPER: begin
            next_rd = nco_byte(cif.acc, 2'h2);
         end
         OFS_INC_LOW: begin
            next_rd = nco_byte(incr, 2'h0); // R8
         end
         OFS_INC_HIGH: begin
            next_rd = nco_byte(incr, 2'h1);
         end
         OFS_INC_UPPER: begin
            next_rd = nco_byte(incr, 2'h2);
         end
         OFS_IRQ: begin
            next_rd[IRQ_FLAG_BIT] = overflow_irq_flag;
            next_rd[IRQ_IE_BIT] = overflow_irq_enable;
            next_rd[IRQ_PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable;
            next_rd[IRQ_GIE_BIT] = global_irq_enable;
            next_rd[IRQ_PIN_BIT] = pin_drive;
         end
         default: begin
            next_rd = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wb_dat_o <= 32'h00000000;
      end else if (ce && wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         wb_dat_o <= {24'h000000, next_rd};
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking top_clk @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_ctrl_write_pol;
      ce && do_write && wb_adr_i == OFS_CTRL && wr_byte[CTRL_POL_BIT] != output_invert;
   endsequence

   flag_set_a: assert property (ce && cif.ovf |=> overflow_irq_flag)
      else $error("overflow did not set the flag"); // R17
   flag_sticky_a: assert property (ce && overflow_irq_flag && !(do_write && wb_adr_i == OFS_IRQ)
         |=> overflow_irq_flag)
      else $error("flag cleared without software"); // R18
   irq_gate_a: assert property (ce && irq_request |-> $past(overflow_irq_flag)
         && $past(module_enable) && $past(global_irq_enable))
      else $error("request without all enables"); // R17
   pol_irq_a: assert property (s_ctrl_write_pol ##1 ce && overflow_irq_enable |=> overflow_irq_flag)
      else $error("polarity change gave no interrupt"); // R15
   pol_out_a: assert property (ce |=> final_output == $past(cif.out_raw ^ output_invert))
      else $error("output polarity stage wrong"); // R14
   fast_keep_a: assert property (ce && module_enable && input_clock_select == CKS_FAST_OSC
         |=> fast_osc_keep)
      else $error("fast oscillator not held"); // R21
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
endmodule : nco_top
`default_nettype wire
